// File: core/wppf_pkg.sv
// Shared constants, types and functions for the WAN PHY medium-attachment framer.
// Assumes one 250 MHz clock; one frame octet is handled per clock edge.
package wppf_pkg;

  // ==========================================================
  // Data widths and buffer depth
  localparam int unsigned OCTET_W    = 8;       // Service octet width
  localparam int unsigned WORD_W     = 16;      // Medium word width
  localparam int unsigned FIFO_DEPTH = 8;       // Transmit payload buffer octets

  // ==========================================================
  // Rates (nominal line rates and local clock, in kHz)
  localparam int unsigned OCTET_RATE_KHZ  = 1244160;  // Octets per second / 1000
  localparam int unsigned WORD_RATE_KHZ   = 622080;   // Words per second / 1000
  localparam int unsigned CLK_RATE_KHZ    = 250000;   // Local clock
  localparam int unsigned OCTETS_PER_WORD = OCTET_RATE_KHZ / WORD_RATE_KHZ;

  // ==========================================================
  // Frame geometry (octet columns, rows)
  localparam logic [14:0] FRAME_COLS   = 15'd17280;  // Columns in a row
  localparam logic [3:0]  FRAME_ROWS   = 4'd9;       // Rows in a frame
  localparam logic [14:0] TOH_COLS     = 15'd576;    // Transport overhead width
  localparam logic [14:0] SCR_LAST_COL = 15'd575;    // Last unscrambled octet of row 0
  localparam logic [14:0] POH_COL      = 15'd576;    // Path overhead column
  localparam logic [14:0] PAY_COL      = 15'd640;    // First payload column
  localparam logic [14:0] ALIGN1_END   = 15'd192;    // End of first alignment run
  localparam logic [14:0] ALIGN2_END   = 15'd384;    // End of second alignment run
  localparam logic [14:0] TRACE_COL    = 15'd384;    // Section trace octet
  localparam logic [14:0] LOCK_COL     = 15'd191;    // Last first-alignment column
  localparam logic [14:0] RELOCK_COL   = 15'd193;    // Column after the lock word
  localparam logic [3:0]  PTR_ROW      = 4'd3;       // Pointer row

  // ==========================================================
  // Overhead octet values
  localparam logic [7:0] FRAME_ALIGN_FIRST  = 8'hF6;
  localparam logic [7:0] FRAME_ALIGN_SECOND = 8'h28;
  localparam logic [7:0] TRACE_OCT          = 8'h02;
  localparam logic [7:0] GROWTH_OCT         = 8'hCC;
  localparam logic [7:0] PTR_HI_FIRST       = 8'h62;  // Normal flag, pointer 522
  localparam logic [7:0] PTR_LO_FIRST       = 8'h0A;
  localparam logic [7:0] PTR_HI_REST        = 8'h93;  // Concatenation marks
  localparam logic [7:0] PTR_LO_REST        = 8'hFF;
  localparam logic [7:0] ZERO_OCT           = 8'h00;
  localparam logic [15:0] ALIGN_WORD        = 16'hF628;
  localparam logic [6:0]  SCR_SEED          = 7'h7F;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [3:0]  row;
    logic [14:0] col;
  } wppf_pos_type;

  typedef struct packed {
    logic [15:0] data;
    logic        stb;
  } wppf_word_type;

  typedef enum logic {
    WPPF_HUNT = 1'b0,
    WPPF_SYNC = 1'b1
  } wppf_sync_type;

  // ==========================================================
  // Shared functions
  // Advance a frame position by one octet
  function automatic wppf_pos_type pos_next(input wppf_pos_type p);
    wppf_pos_type n;
    n = p;
    if (p.col == FRAME_COLS - 15'd1) begin
      n.col = '0;
      n.row = (p.row == FRAME_ROWS - 4'd1) ? '0 : p.row + 4'd1;
    end else begin
      n.col = p.col + 15'd1;
    end
    return n;
  endfunction

  // One octet of keystream, MSB first, and the advanced state
  function automatic logic [14:0] scr_step(input logic [6:0] s);
    logic [7:0] ks;
    logic [6:0] st;
    st = s;
    ks = '0;
    for (int i = 7; i >= 0; i--) begin
      ks[i] = st[6];
      st    = {st[5:0], st[6] ^ st[5]};
    end
    return {ks, st};
  endfunction

  // Octets of row 0 ahead of the path column stay in clear
  function automatic logic in_clear_row(input wppf_pos_type p);
    return (p.row == 4'd0) && (p.col < TOH_COLS);
  endfunction

  // Overhead and fixed-stuff content for non-payload positions
  function automatic logic [7:0] oh_octet(input wppf_pos_type p);
    logic [7:0] o;
    o = ZERO_OCT;
    if (p.row == 4'd0 && p.col < ALIGN1_END) begin
      o = FRAME_ALIGN_FIRST;
    end else if (p.row == 4'd0 && p.col < ALIGN2_END) begin
      o = FRAME_ALIGN_SECOND;
    end else if (p.row == 4'd0 && p.col == TRACE_COL) begin
      o = TRACE_OCT;
    end else if (p.row == 4'd0 && p.col < TOH_COLS) begin
      o = GROWTH_OCT;
    end else if (p.row == PTR_ROW && p.col < ALIGN1_END) begin
      o = (p.col == 15'd0) ? PTR_HI_FIRST : PTR_HI_REST;
    end else if (p.row == PTR_ROW && p.col < ALIGN2_END) begin
      o = (p.col == ALIGN1_END) ? PTR_LO_FIRST : PTR_LO_REST;
    end
    return o;
  endfunction

endpackage

// File: core/wppf_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module wppf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     in_valid_in,
  input  wire logic [WIDTH-1:0]         in_data_in,
  output logic                          in_ready_out,
  output logic                          out_valid_out,
  output logic [WIDTH-1:0]              out_data_out,
  input  wire logic                     out_ready_in,
  output logic [$clog2(DEPTH):0]        count_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];       // Storage
  logic [AW-1:0]    wr_r, wr_nxt;        // Write pointer
  logic [AW-1:0]    rd_r, rd_nxt;        // Read pointer
  logic [AW:0]      cnt_r, cnt_nxt;      // Occupancy
  logic             push, pop;

  // ==========================================================
  // Handshake and pointer update
  always_comb begin
    push    = in_valid_in && (cnt_r != DEPTH[AW:0]);
    pop     = out_ready_in && (cnt_r != '0);
    wr_nxt  = push ? ((wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? ((rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // Registers; storage holds no reset since empty words are never read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end

  assign in_ready_out  = (cnt_r != DEPTH[AW:0]);
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rd_r];
  assign count_out     = cnt_r;
endmodule
`default_nettype wire

// File: core/wppf_framer.sv
// Medium-attachment framer: maps service octets into scrambled frames,
// and finds, descrambles and strips received frames back to payload.
// Assumes one frame octet per clock; medium words every second clock.
//
// Contract
// RQ1: Source holds octet until accept sampled high.
// RQ2: Take octet only while accept is high.
// RQ3: Octets move at nominal 1.24416 GHz rate; the code moves one octet per 250 MHz clock instead.
// RQ4: Transmit octet is 8 bits, bit 7 MSB.
// RQ5: Receive bus holds latest payload octet, MSB 7.
// RQ6: Map accepted octets; emit words without gaps.
// RQ7: Pack frame octets into 16-bit words.
// RQ8: Word sends its most significant bits first.
// RQ9: Scramble frames with x^7+x^6+1 frame-synchronous scrambler.
// RQ10: Overheads, scramble, then clear alignment row.
// RQ11: Deserialize received words before frame search.
// RQ12: Receive input from medium or loopback.
// RQ13: Find frame by alignment byte pattern.
// RQ14: No octets while synchronisation is lost.
// RQ15: Drop first 576 octets before descrambling.
// RQ16: Descramble with the same scrambler.
// RQ17: Strip remaining overheads and fixed stuff.
// RQ18: Valid high exactly with a new octet.
// RQ19: One octet per aligned payload octet.
// RQ20: Alignment bytes are F6 then 28.
// RQ21: Overhead spans 576 columns, 3+6 rows.
// RQ22: Sixty-three fixed-stuff columns carry zeros.
// RQ23: Earlier octet goes in the upper byte.
`timescale 1ns/1ns
`default_nettype none
module wppf_framer
  import wppf_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [7:0]    tx_octet_in,
  output logic               tx_accept_out,
  output logic [15:0]        tx_word_out,
  output logic               tx_word_stb_out,
  input  wire logic [15:0]   rx_word_in,
  input  wire logic          rx_word_stb_in,
  input  wire logic          loopback_in,
  output logic [7:0]         rx_octet_out,
  output logic               rx_valid_out,
  output logic               rx_lock_out
);

  // ==========================================================
  // Transmit payload buffer
  logic        fifo_out_valid;  // Buffered octet waiting
  logic [7:0]  fifo_out_data;   // Oldest octet
  logic        fifo_pop;        // Framer takes an octet
  logic        fifo_in_ready;   // Space left
  logic [3:0]  fifo_count;      // Occupancy
  logic        accept_r, accept_nxt;

  // RQ3 RQ4: one octet per clock
  // RQ2: push only on accept
  wppf_fifo #(
    .WIDTH (OCTET_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (accept_r),
    .in_data_in    (tx_octet_in),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (fifo_pop),
    .count_out     (fifo_count)
  );

  // ==========================================================
  // Transmit frame generator
  wppf_pos_type tx_pos_r, tx_pos_nxt;    // Position being built
  wppf_pos_type tx_opos_r, tx_opos_nxt;  // Position of tx_oct_r
  logic [7:0]   tx_oct_r, tx_oct_nxt;    // Unscrambled octet
  logic [6:0]   tx_scr_r, tx_scr_nxt;    // Scrambler state
  logic [7:0]   tx_hi_r, tx_hi_nxt;      // Earlier octet of a word
  logic [15:0]  tx_word_r, tx_word_nxt;  // Word to the medium
  logic         tx_stb_r, tx_stb_nxt;    // Word strobe
  logic [7:0]   tx_scr_oct;              // Octet after scrambling
  logic [14:0]  tx_ks;                   // Keystream and next state
  logic [4:0]   room_sum;                // Worst-case next occupancy

  always_comb begin
    // Accept only if a push next cycle still fits, so no octet is dropped
    room_sum   = {1'b0, fifo_count} + {4'd0, accept_r};
    accept_nxt = (room_sum < 5'(FIFO_DEPTH));
    tx_pos_nxt = pos_next(tx_pos_r);
    // RQ20 RQ21 RQ22: overhead and stuff from table
    fifo_pop   = 1'b0;
    tx_oct_nxt = oh_octet(tx_pos_r);
    if (tx_pos_r.col >= PAY_COL) begin
      // Underrun fills with zero rather than stalling the line
      fifo_pop   = fifo_out_valid;
      tx_oct_nxt = fifo_out_valid ? fifo_out_data : ZERO_OCT;
    end
    tx_opos_nxt = tx_pos_r;
    // RQ9: frame-synchronous scrambling
    tx_ks      = scr_step(tx_scr_r);
    tx_scr_oct = tx_oct_r ^ tx_ks[14:7];
    tx_scr_nxt = tx_ks[6:0];
    // RQ10: alignment row bypasses the scrambler
    if (in_clear_row(tx_opos_r)) begin
      tx_scr_oct = tx_oct_r;
      tx_scr_nxt = (tx_opos_r.col == SCR_LAST_COL) ? SCR_SEED : tx_scr_r;
    end
    // RQ6 RQ7 RQ8: word every second clock
    // RQ23: even column is the upper byte
    tx_hi_nxt   = tx_hi_r;
    tx_word_nxt = tx_word_r;
    tx_stb_nxt  = 1'b0;
    if (!tx_opos_r.col[0]) begin
      tx_hi_nxt = tx_scr_oct;
    end else begin
      tx_word_nxt = {tx_hi_r, tx_scr_oct};
      tx_stb_nxt  = 1'b1;
    end
  end

  // Transmit registers; reset parks on an even column so no half word leaves
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      accept_r  <= 1'b0;
      tx_pos_r  <= '0;
      tx_opos_r <= '{row: FRAME_ROWS - 4'd1, col: FRAME_COLS - 15'd2};
      tx_oct_r  <= ZERO_OCT;
      tx_scr_r  <= SCR_SEED;
      tx_hi_r   <= ZERO_OCT;
      tx_word_r <= 16'h0000;
      tx_stb_r  <= 1'b0;
    end else begin
      accept_r  <= accept_nxt;
      tx_pos_r  <= tx_pos_nxt;
      tx_opos_r <= tx_opos_nxt;
      tx_oct_r  <= tx_oct_nxt;
      tx_scr_r  <= tx_scr_nxt;
      tx_hi_r   <= tx_hi_nxt;
      tx_word_r <= tx_word_nxt;
      tx_stb_r  <= tx_stb_nxt;
    end
  end

  // ==========================================================
  // Receive word source, synchroniser and octet split
  wppf_word_type src;                    // Selected word source
  wppf_sync_type sync_r, sync_nxt;       // Frame lock state
  logic [3:0]    off_r, off_nxt;         // Bit offset of octet boundary
  logic [15:0]   prev_r, prev_nxt;       // Previous received word
  wppf_pos_type  wpos_r, wpos_nxt;       // Position of next word's first octet
  logic [7:0]    oa_r, oa_nxt, ob_r, ob_nxt;
  wppf_pos_type  pa_r, pa_nxt, pb_r, pb_nxt;
  logic          ea_r, ea_nxt, eb_r, eb_nxt;  // Pending octet emits
  logic [31:0]   win;                    // Two-word bit window
  logic [15:0]   aw;                     // Aligned word
  logic          hit;
  logic [3:0]    hit_off;

  always_comb begin
    // RQ12: loopback takes the own transmit words
    src  = loopback_in ? '{data: tx_word_r, stb: tx_stb_r}
                       : '{data: rx_word_in, stb: rx_word_stb_in};
    // RQ11: words become a bit window, earliest bit highest
    win     = {prev_r, src.data};
    hit     = 1'b0;
    hit_off = '0;
    // RQ13: search every bit offset for the alignment boundary
    for (int k = 15; k >= 0; k--) begin
      if (win[31 - k -: 16] == ALIGN_WORD) begin
        hit     = 1'b1;
        hit_off = 4'(k);
      end
    end
    aw       = win[31 - off_r -: 16];
    sync_nxt = sync_r;
    off_nxt  = off_r;
    prev_nxt = src.stb ? src.data : prev_r;
    wpos_nxt = wpos_r;
    oa_nxt   = oa_r;
    ob_nxt   = ob_r;
    pa_nxt   = pa_r;
    pb_nxt   = pb_r;
    ea_nxt   = 1'b0;
    eb_nxt   = ea_r;
    if (src.stb) begin
      if (sync_r == WPPF_HUNT) begin
        if (hit) begin
          sync_nxt = WPPF_SYNC;
          off_nxt  = hit_off;
          wpos_nxt = '{row: 4'd0, col: RELOCK_COL};
        end
      end else if (wpos_r.row == 4'd0 && wpos_r.col == LOCK_COL && aw != ALIGN_WORD) begin
        // RQ14: lost lock drops anything pending
        sync_nxt = WPPF_HUNT;
        eb_nxt   = 1'b0;
      end else begin
        oa_nxt   = aw[15:8];
        ob_nxt   = aw[7:0];
        pa_nxt   = wpos_r;
        pb_nxt   = pos_next(wpos_r);
        wpos_nxt = pos_next(pos_next(wpos_r));
        ea_nxt   = 1'b1;
      end
    end
  end

  // Receive front registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_r <= WPPF_HUNT;
      off_r  <= '0;
      prev_r <= 16'h0000;
      wpos_r <= '0;
      oa_r   <= ZERO_OCT;
      ob_r   <= ZERO_OCT;
      pa_r   <= '0;
      pb_r   <= '0;
      ea_r   <= 1'b0;
      eb_r   <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      off_r  <= off_nxt;
      prev_r <= prev_nxt;
      wpos_r <= wpos_nxt;
      oa_r   <= oa_nxt;
      ob_r   <= ob_nxt;
      pa_r   <= pa_nxt;
      pb_r   <= pb_nxt;
      ea_r   <= ea_nxt;
      eb_r   <= eb_nxt;
    end
  end

  // ==========================================================
  // Receive descrambler and overhead stripping
  logic [6:0]   rx_scr_r, rx_scr_nxt;      // Descrambler state
  logic [7:0]   rx_oct_r, rx_oct_nxt;      // Delivered octet
  logic         rx_val_r, rx_val_nxt;      // Delivery strobe
  logic [7:0]   cur_oct;
  wppf_pos_type cur_pos;
  logic         cur_act;
  logic [14:0]  rx_ks;

  always_comb begin
    cur_oct    = ea_r ? oa_r : ob_r;
    cur_pos    = ea_r ? pa_r : pb_r;
    cur_act    = (ea_r || eb_r) && (sync_r == WPPF_SYNC);
    rx_ks      = scr_step(rx_scr_r);
    rx_scr_nxt = rx_scr_r;
    rx_oct_nxt = rx_oct_r;
    rx_val_nxt = 1'b0;
    if (cur_act) begin
      if (in_clear_row(cur_pos)) begin
        // RQ15: clear row is dropped, reseeding at its end
        if (cur_pos.col == SCR_LAST_COL) begin
          rx_scr_nxt = SCR_SEED;
        end
      end else begin
        // RQ16: same keystream as the transmitter
        rx_scr_nxt = rx_ks[6:0];
        // RQ17: only payload columns go upward
        if (cur_pos.col >= PAY_COL) begin
          // RQ5 RQ18 RQ19: octet and strobe together
          rx_oct_nxt = cur_oct ^ rx_ks[14:7];
          rx_val_nxt = 1'b1;
        end
      end
    end
  end

  // Receive back registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_scr_r <= SCR_SEED;
      rx_oct_r <= ZERO_OCT;
      rx_val_r <= 1'b0;
    end else begin
      rx_scr_r <= rx_scr_nxt;
      rx_oct_r <= rx_oct_nxt;
      rx_val_r <= rx_val_nxt;
    end
  end

  assign tx_accept_out   = accept_r;
  assign tx_word_out     = tx_word_r;
  assign tx_word_stb_out = tx_stb_r;
  assign rx_octet_out    = rx_oct_r;
  assign rx_valid_out    = rx_val_r;
  assign rx_lock_out     = sync_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence word_gap;
    !tx_stb_r ##1 tx_stb_r;
  endsequence

  accept_has_room_a: assert property (accept_r |-> fifo_in_ready) // RQ2
    else $error("accept raised with buffer full");
  word_cadence_a: assert property (tx_stb_r |=> word_gap) // RQ6
    else $error("transmit words not every second cycle");
  word_pack_order_a: assert property (tx_stb_r |-> // RQ23
      tx_word_r == {$past(tx_scr_oct, 2), $past(tx_scr_oct, 1)})
    else $error("word octet order wrong");
  align_first_a: assert property ((tx_opos_r.row == 4'd0 && // RQ20
      tx_opos_r.col < ALIGN1_END) |-> tx_scr_oct == FRAME_ALIGN_FIRST)
    else $error("first alignment octet wrong");
  stuff_zero_a: assert property ((tx_opos_r.col >= POH_COL + 15'd1 && // RQ22
      tx_opos_r.col < PAY_COL) |-> tx_oct_r == ZERO_OCT)
    else $error("fixed stuff not zero");
  scr_reseed_a: assert property ((tx_opos_r.row == 4'd0 && // RQ9
      tx_opos_r.col == SCR_LAST_COL) |=> tx_scr_r == SCR_SEED)
    else $error("scrambler not reseeded");
  hunt_silent_a: assert property ((sync_r == WPPF_HUNT)[*2] |-> !rx_val_r) // RQ14
    else $error("octet delivered without lock");
  payload_only_a: assert property (rx_val_r |-> // RQ17
      $past(cur_pos.col) >= PAY_COL && !$past(in_clear_row(cur_pos)))
    else $error("overhead octet delivered");
  valid_new_a: assert property (rx_val_r |-> $past(cur_act)) // RQ18
    else $error("valid without a new octet");
endmodule
`default_nettype wire

// File: verif/wppf_pcs_model.sv
// Coding-side source model: offers a counting octet stream to the framer.
// Assumes the framer's accept level is registered and sampled on rising edges.
`timescale 1ns/1ns
`default_nettype none
module wppf_pcs_model (
  input  wire logic       clk_in,       // Framer clock
  input  wire logic       rst_n_in,     // Synchronous reset, active low
  input  wire logic       tx_accept_in, // Accept level from the framer
  output logic [7:0]      tx_octet_out  // Offered octet, bit 7 MSB
);
  // ==========================================================
  // Hand-off state
  logic taken_r; // Octet was taken at the last rising edge

  initial begin
    taken_r = 1'b0;
    tx_octet_out = 8'h01;
  end

  // Note what the framer took; only a high accept counts
  always @(posedge clk_in) begin
    taken_r <= rst_n_in & tx_accept_in;
  end

  // hold until taken
  // Advance off the sampling edge so the framer never sees a changing octet
  always @(negedge clk_in) begin
    if (!rst_n_in) begin
      tx_octet_out <= 8'h01;
    end else if (taken_r) begin
      tx_octet_out <= tx_octet_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the framer: transmit frame layout in loopback,
// then frame search on the medium input with a bit-shifted pattern.
// Assumes a frame is far longer than the run, so lock loss is not reached.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import wppf_pkg::*;
;
  // ==========================================================
  // Stimulus and observation signals
  logic        clk_in;          // 250 MHz clock
  logic        rst_n_in;        // Reset, active low
  logic [7:0]  tx_octet_in;     // From source model
  logic        tx_accept_out;   // Framer accept level
  logic [15:0] tx_word_out;     // Medium word out
  logic        tx_word_stb_out; // Medium word strobe
  logic [15:0] rx_word_in;      // Medium word in
  logic        rx_word_stb_in;  // Medium word strobe in
  logic        loopback_in;     // Receive source select
  logic [7:0]  rx_octet_out;    // Payload octet out
  logic        rx_valid_out;    // Payload strobe
  logic        rx_lock_out;     // Frame lock
  int          n_errors;        // Mismatches
  int          n_tests;         // Comparisons
  logic [7:0]  oq[$];           // Transmitted octets in frame order
  int          gap;             // Cycles since last word strobe
  bit          seen;            // A word strobe was seen
  logic [7:0]  rq[$];           // Delivered payload octets

  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    rx_word_in = 16'h0000;
    rx_word_stb_in = 1'b0;
    loopback_in = 1'b0;
    n_errors = 0;
    n_tests = 0;
  end

  always #2 clk_in = ~clk_in;

  wppf_framer i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .tx_octet_in(tx_octet_in),
    .tx_accept_out(tx_accept_out), .tx_word_out(tx_word_out),
    .tx_word_stb_out(tx_word_stb_out), .rx_word_in(rx_word_in),
    .rx_word_stb_in(rx_word_stb_in), .loopback_in(loopback_in),
    .rx_octet_out(rx_octet_out), .rx_valid_out(rx_valid_out), .rx_lock_out(rx_lock_out)
  );

  wppf_pcs_model i_src (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .tx_accept_in(tx_accept_out),
    .tx_octet_out(tx_octet_in)
  );

  // ==========================================================
  // Shared helpers
  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      n_errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Keystream octet n after the seed point, first bit in bit 7
  function automatic logic [7:0] ks(input int n);
    logic [6:0] s;
    logic [7:0] o;
    s = 7'h7F;
    o = 8'h00;
    for (int i = 0; i < n * 8 + 8; i++) begin
      if (i >= n * 8) begin
        o = {o[6:0], s[6]};
      end
      s = {s[5:0], s[6] ^ s[5]};
    end
    return o;
  endfunction

  // Hold reset 8 cycles, check reset outputs, then release
  task automatic do_reset(input logic lb);
    @(negedge clk_in);
    rst_n_in = 1'b0;
    loopback_in = lb;
    repeat (8) @(negedge clk_in);
    chk({tx_accept_out, tx_word_out, tx_word_stb_out} === 18'h0_0000, "tx reset");
    chk({rx_octet_out, rx_valid_out, rx_lock_out} === 10'h000, "rx reset");
    rst_n_in = 1'b1;
  endtask

  // One medium word; strobes stay two cycles apart
  task automatic send_word(input logic [15:0] w);
    @(negedge clk_in);
    rx_word_in = w;
    rx_word_stb_in = 1'b1;
    @(negedge clk_in);
    rx_word_stb_in = 1'b0;
  endtask

  // ==========================================================
  // Monitors: collect octets, watch strobe spacing and payload gating
  always @(negedge clk_in) begin
    if (!rst_n_in) begin
      oq.delete();
      rq.delete();
      gap = 0;
      seen = 0;
    end else begin
      gap++;
      if (tx_word_stb_out === 1'b1) begin
        if (seen) chk(gap == 2, "word strobe spacing");
        gap = 0;
        seen = 1;
        oq.push_back(tx_word_out[15:8]);
        oq.push_back(tx_word_out[7:0]);
      end
      if (rx_valid_out === 1'b1) rq.push_back(rx_octet_out);
      if (rx_valid_out !== 1'b0 && rx_lock_out !== 1'b1) chk(0, "octet while unlocked");
    end
  end

  // ==========================================================
  // Loopback run: frame layout, scrambling, payload order, lock
  task automatic sc_loopback_tx();
    int t;
    int low;
    logic [7:0] e;
    do_reset(1'b1);
    t = 0;
    low = 0;
    while (oq.size() < 704 && t < 2000) begin
      @(negedge clk_in);
      t++;
      if (tx_accept_out === 1'b0) low++;
      if (t == 150) chk(rx_lock_out === 1'b0, "lock before pattern");
      if (t == 400) chk(rx_lock_out === 1'b1, "no lock in loopback");
    end
    if (t >= 2000) begin
      chk(0, "transmit words stalled");
    end
    chk(low > 0, "accept never paused for overhead");
    // Unscrambled first row, then keystream over zero stuff, then payload
    for (int c = 0; c < 704; c++) begin
      if (c < 192) e = FRAME_ALIGN_FIRST;
      else if (c < 384) e = FRAME_ALIGN_SECOND;
      else if (c == 384) e = TRACE_OCT;
      else if (c < 576) e = GROWTH_OCT;
      else if (c < 640) e = ks(c - 576);
      else e = 8'(c - 639) ^ ks(c - 576);
      chk(oq[c] === e, $sformatf("octet at column %0d", c));
    end
  endtask

  // Medium run: own transmit ignored, pattern found at a 12-bit offset
  task automatic sc_medium_lock();
    int t;
    do_reset(1'b0);
    repeat (250) send_word(16'h0000);
    chk(rx_lock_out === 1'b0, "lock taken from own transmit");
    send_word(16'h000F);
    send_word(16'h6280);
    t = 0;
    while (rx_lock_out !== 1'b1 && t < 8) begin
      send_word(16'h0000);
      t++;
    end
    chk(rx_lock_out === 1'b1, "shifted pattern not found");
  endtask

  // Medium run at offset 0: clear row and stuff dropped, payload descrambled
  // Lock lands on the word after the pattern; word n then holds columns 191+2n, 192+2n
  task automatic sc_medium_payload();
    do_reset(1'b0);
    send_word(16'hF628);
    repeat (223) send_word(16'h0000);
    chk(rx_lock_out === 1'b1 && rq.size() == 0, "overhead delivered");
    send_word({8'h00, 8'hA5 ^ ks(64)});
    send_word({8'h3C ^ ks(65), 8'h96 ^ ks(66)});
    send_word(16'h0000);
    repeat (4) @(negedge clk_in);
    chk(rq.size() == 3, "payload octet count");
    chk({rq[0], rq[1], rq[2]} === 24'hA5_3C96, "payload octets");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    sc_loopback_tx();
    sc_medium_lock();
    sc_medium_payload();
    stop_test();
  end
endmodule
`default_nettype wire
